// ==== core/pgtm_top.sv ====
// Mask register bank and power-good combination for the second status output.
// Assumes one clock CLK, synchronous reset SRST, and AHB-Lite as sole register path;
// all source inputs arrive asynchronously and are synchronised here.
//
// Behaviour
// - Bit 7 masks fifth control input state
// - Bit 6 masks fourth control input state
// - Bit 5 masks second control input state
// - Bit 4 masks first control input state
// - Bit 3 masks termination regulator good flag
// - Bit 2 masks shared rail good flag
// - Bit 1 masks first B switch flag
// - Bit 0 masks third A regulator flag
`default_nettype none

module pgtm_top #(
  parameter logic [7:0] MASK_B_RESET = pgtm_pkg::PGTM_RST_MASK_B,
  parameter logic [7:0] MASK_A_RESET = pgtm_pkg::PGTM_RST_MASK_A
) (
  input  wire logic        CLK,
  input  wire logic        SRST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [7:0]  HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  // Power-good sources, all asynchronous to CLK
  input  wire logic        FIFTH_CONTROL_INPUT,
  input  wire logic        FOURTH_CONTROL_INPUT,
  input  wire logic        SECOND_CONTROL_INPUT,
  input  wire logic        FIRST_CONTROL_INPUT,
  input  wire logic        TERMINATION_POWER_GOOD_FLAG,
  input  wire logic        SHARED_RAIL_POWER_GOOD_FLAG,
  input  wire logic        FIRST_B_SWITCH_POWER_GOOD_FLAG,
  input  wire logic        THIRD_A_REGULATOR_POWER_GOOD_FLAG,
  input  wire logic [7:0]  COMPANION_POWER_GOOD_FLAGS,
  // Combined result
  output logic             SECOND_STATUS_OUTPUT_PIN
);

  // Bus decode helpers
  typedef enum logic [2:0] {
    PGTM_REG_MASK_B = 3'b001,
    PGTM_REG_MASK_A = 3'b010,
    PGTM_REG_STATUS = 3'b100
  } pgtm_reg_e;

  // Maps a byte address to a one-hot register select, zero if unmapped
  function automatic logic [2:0] pgtm_decode(input logic [7:0] addr);
    logic [2:0] hit;
    hit = 3'h0;
    case (addr)
      pgtm_pkg::PGTM_OFS_MASK_B: hit = PGTM_REG_MASK_B;
      pgtm_pkg::PGTM_OFS_MASK_A: hit = PGTM_REG_MASK_A;
      pgtm_pkg::PGTM_OFS_STATUS: hit = PGTM_REG_STATUS;
      default:                   hit = 3'h0;
    endcase
    return hit;
  endfunction

  // Combines sources with masks: a set mask bit forces that source to good
  function automatic logic pgtm_tree(input logic [7:0] src, input logic [7:0] msk);
    return &(src | msk);
  endfunction

  pgtm_pkg::pgtm_ahb_req_s req;
  pgtm_pkg::pgtm_ahb_req_s dph_r;
  pgtm_pkg::pgtm_src_b_s   src_raw;
  pgtm_pkg::pgtm_src_b_s   src_b;
  logic [7:0]              sync_b1_r;
  logic [7:0]              sync_b2_r;
  logic [7:0]              sync_a1_r;
  logic [7:0]              sync_a2_r;
  logic [7:0]              mask_b_r;
  logic [7:0]              mask_a_r;
  logic                    dph_valid_r;
  logic                    addr_take;
  logic [2:0]              addr_hit;
  logic [2:0]              dph_hit;
  logic [31:0]             rdata_nxt;
  logic                    pin_nxt;

  // Pack the address phase and the raw sources
  assign req = '{sel:   HSEL,
                 trans: HTRANS,
                 write: HWRITE,
                 size:  HSIZE,
                 addr:  HADDR};

  assign src_raw = '{fifth_control_input:          FIFTH_CONTROL_INPUT,
                     fourth_control_input:         FOURTH_CONTROL_INPUT,
                     second_control_input:         SECOND_CONTROL_INPUT,
                     first_control_input:          FIRST_CONTROL_INPUT,
                     memory_termination_regulator: TERMINATION_POWER_GOOD_FLAG,
                     shared_rail:                  SHARED_RAIL_POWER_GOOD_FLAG,
                     first_b_load_switch:          FIRST_B_SWITCH_POWER_GOOD_FLAG,
                     third_a_regulator:            THIRD_A_REGULATOR_POWER_GOOD_FLAG};

  // Two-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sync_b1_r <= 8'h00;
      sync_b2_r <= 8'h00;
      sync_a1_r <= 8'h00;
      sync_a2_r <= 8'h00;
    end else begin
      sync_b1_r <= src_raw;
      sync_b2_r <= sync_b1_r;
      sync_a1_r <= COMPANION_POWER_GOOD_FLAGS;
      sync_a2_r <= sync_a1_r;
    end
  end

  assign src_b = pgtm_pkg::pgtm_src_b_s'(sync_b2_r);

  // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready
  assign addr_take = req.sel && HREADY && (req.trans == pgtm_pkg::PGTM_HTRANS_NONSEQ ||
                                           req.trans == 2'h3);
  assign addr_hit  = pgtm_decode(req.addr);
  assign dph_hit   = pgtm_decode(dph_r.addr);

  // Address phase capture; the data phase always completes in one cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      dph_valid_r <= 1'b0;
      dph_r       <= '0;
    end else begin
      dph_valid_r <= addr_take;
      if (addr_take) begin
        dph_r <= req;
      end
    end
  end

  // Zero wait states and OKAY only, so both are constant flip-flops
  always_ff @(posedge CLK) begin
    if (SRST) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // Read mux evaluated on the address phase so data stands in the data phase
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (addr_hit)
      PGTM_REG_MASK_B: rdata_nxt[7:0] = mask_b_r;
      PGTM_REG_MASK_A: rdata_nxt[7:0] = mask_a_r;
      PGTM_REG_STATUS: begin
        rdata_nxt[pgtm_pkg::PGTM_STAT_SRC_B_LSB +: 8] = sync_b2_r;
        rdata_nxt[pgtm_pkg::PGTM_STAT_SRC_A_LSB +: 8] = sync_a2_r;
        rdata_nxt[pgtm_pkg::PGTM_STAT_PIN_BIT]        = SECOND_STATUS_OUTPUT_PIN;
      end
      default:         rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data register; unmapped addresses and writes read as zero
  always_ff @(posedge CLK) begin
    if (SRST) begin
      HRDATA <= 32'h0000_0000;
    end else if (addr_take && !req.write) begin
      HRDATA <= rdata_nxt;
    end else begin
      HRDATA <= 32'h0000_0000;
    end
  end

  // Mask B: each bit drops one source of this output's tree
  // A write landing in the same cycle as reset release is simply not taken.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mask_b_r <= MASK_B_RESET;
    end else if (dph_valid_r && dph_r.write && dph_hit == PGTM_REG_MASK_B) begin
      mask_b_r[pgtm_pkg::PGTM_BIT_FIFTH_CTL]  <= HWDATA[pgtm_pkg::PGTM_BIT_FIFTH_CTL];
      mask_b_r[pgtm_pkg::PGTM_BIT_FOURTH_CTL] <= HWDATA[pgtm_pkg::PGTM_BIT_FOURTH_CTL];
      mask_b_r[pgtm_pkg::PGTM_BIT_SECOND_CTL] <= HWDATA[pgtm_pkg::PGTM_BIT_SECOND_CTL];
      mask_b_r[pgtm_pkg::PGTM_BIT_FIRST_CTL]  <= HWDATA[pgtm_pkg::PGTM_BIT_FIRST_CTL];
      mask_b_r[pgtm_pkg::PGTM_BIT_TERM_REG]   <= HWDATA[pgtm_pkg::PGTM_BIT_TERM_REG];
      mask_b_r[pgtm_pkg::PGTM_BIT_SHARED]     <= HWDATA[pgtm_pkg::PGTM_BIT_SHARED];
      mask_b_r[pgtm_pkg::PGTM_BIT_FIRST_B_SW] <= HWDATA[pgtm_pkg::PGTM_BIT_FIRST_B_SW];
      mask_b_r[pgtm_pkg::PGTM_BIT_THIRD_A]    <= HWDATA[pgtm_pkg::PGTM_BIT_THIRD_A];
    end
  end

  // Companion mask A for the remaining eight sources of the same tree
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mask_a_r <= MASK_A_RESET;
    end else if (dph_valid_r && dph_r.write && dph_hit == PGTM_REG_MASK_A) begin
      mask_a_r <= HWDATA[7:0];
    end
  end

  // Tree: masked sources are forced good, every other must report good
  always_comb begin
    pin_nxt = 1'b1;
    if (!(src_b.fifth_control_input || mask_b_r[pgtm_pkg::PGTM_BIT_FIFTH_CTL])) begin
      pin_nxt = 1'b0;
    end
    if (!(src_b.fourth_control_input || mask_b_r[pgtm_pkg::PGTM_BIT_FOURTH_CTL])) begin
      pin_nxt = 1'b0;
    end
    if (!(src_b.second_control_input || mask_b_r[pgtm_pkg::PGTM_BIT_SECOND_CTL])) begin
      pin_nxt = 1'b0;
    end
    if (!(src_b.first_control_input || mask_b_r[pgtm_pkg::PGTM_BIT_FIRST_CTL])) begin
      pin_nxt = 1'b0;
    end
    if (!(src_b.memory_termination_regulator || mask_b_r[pgtm_pkg::PGTM_BIT_TERM_REG])) begin
      pin_nxt = 1'b0;
    end
    if (!(src_b.shared_rail || mask_b_r[pgtm_pkg::PGTM_BIT_SHARED])) begin
      pin_nxt = 1'b0;
    end
    if (!(src_b.first_b_load_switch || mask_b_r[pgtm_pkg::PGTM_BIT_FIRST_B_SW])) begin
      pin_nxt = 1'b0;
    end
    if (!(src_b.third_a_regulator || mask_b_r[pgtm_pkg::PGTM_BIT_THIRD_A])) begin
      pin_nxt = 1'b0;
    end
    if (!pgtm_tree(sync_a2_r, mask_a_r)) begin
      pin_nxt = 1'b0;
    end
  end

  // Registered pin; low in reset so no false good is shown while masks settle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SECOND_STATUS_OUTPUT_PIN <= 1'b0;
    end else begin
      SECOND_STATUS_OUTPUT_PIN <= pin_nxt;
    end
  end

endmodule

`default_nettype wire

// ==== core/pgtm_pkg.sv ====
// Package for the power-good tree mask block of the second status output.
// Assumes a single 100 MHz clock and a synchronous, active-high reset.
`default_nettype none

package pgtm_pkg;

  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] PGTM_OFS_MASK_B = 8'h00;
  localparam logic [7:0] PGTM_OFS_MASK_A = 8'h04;
  localparam logic [7:0] PGTM_OFS_STATUS = 8'h08;

  // Bit positions inside second_output_pg_source_mask_b
  localparam int PGTM_BIT_FIFTH_CTL  = 7;
  localparam int PGTM_BIT_FOURTH_CTL = 6;
  localparam int PGTM_BIT_SECOND_CTL = 5;
  localparam int PGTM_BIT_FIRST_CTL  = 4;
  localparam int PGTM_BIT_TERM_REG   = 3;
  localparam int PGTM_BIT_SHARED     = 2;
  localparam int PGTM_BIT_FIRST_B_SW = 1;
  localparam int PGTM_BIT_THIRD_A    = 0;

  // Status register field positions
  localparam int PGTM_STAT_SRC_B_LSB = 0;
  localparam int PGTM_STAT_SRC_A_LSB = 8;
  localparam int PGTM_STAT_PIN_BIT   = 16;

  // Values after reset; the real part differs per variant, so these are defaults
  localparam logic [7:0] PGTM_RST_MASK_B = 8'hFF;
  localparam logic [7:0] PGTM_RST_MASK_A = 8'hFF;

  // AHB transfer types and the word size the bench drives; the slave does not decode HSIZE
  localparam logic [1:0] PGTM_HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] PGTM_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] PGTM_HSIZE_WORD    = 3'h2;

  // Synchroniser depth for pin and flag inputs
  localparam int PGTM_SYNC_STAGES = 2;

  // Address phase of one AHB-Lite transfer
  typedef struct packed {
    logic        sel;
    logic [1:0]  trans;
    logic        write;
    logic [2:0]  size;
    logic [7:0]  addr;
  } pgtm_ahb_req_s;

  // Sources ordered as the bits of mask B
  typedef struct packed {
    logic fifth_control_input;
    logic fourth_control_input;
    logic second_control_input;
    logic first_control_input;
    logic memory_termination_regulator;
    logic shared_rail;
    logic first_b_load_switch;
    logic third_a_regulator;
  } pgtm_src_b_s;

endpackage

`default_nettype wire

// ==== tb/pgtm_monitor.sv ====
// Checker for the second status output mask block: bus answers and pin tree.
// Assumes it is bound to pgtm_top with one clock CLK and reset SRST.
`default_nettype none
module pgtm_monitor #(
  parameter logic [7:0] MASK_B_RESET = 8'hFF,
  parameter logic [7:0] MASK_A_RESET = 8'hFF
) (
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        HSEL,
  input wire logic [7:0]  HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADYOUT,
  input wire logic [31:0] HRDATA,
  input wire logic        HRESP,
  input wire logic        FIFTH_CONTROL_INPUT,
  input wire logic        FOURTH_CONTROL_INPUT,
  input wire logic        SECOND_CONTROL_INPUT,
  input wire logic        FIRST_CONTROL_INPUT,
  input wire logic        TERMINATION_POWER_GOOD_FLAG,
  input wire logic        SHARED_RAIL_POWER_GOOD_FLAG,
  input wire logic        FIRST_B_SWITCH_POWER_GOOD_FLAG,
  input wire logic        THIRD_A_REGULATOR_POWER_GOOD_FLAG,
  input wire logic [7:0]  COMPANION_POWER_GOOD_FLAGS,
  input wire logic        SECOND_STATUS_OUTPUT_PIN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic [7:0] mb_r;
  logic [7:0] ma_r;
  logic       wb_r;
  logic       wa_r;
  wire        wr_go = HSEL && HTRANS[1] && HWRITE;
  wire        rd_go = HSEL && HTRANS[1] && !HWRITE;
  // Sources and masks line up bit for bit, mask B above mask A
  wire        good = &({FIFTH_CONTROL_INPUT, FOURTH_CONTROL_INPUT, SECOND_CONTROL_INPUT,
    FIRST_CONTROL_INPUT, TERMINATION_POWER_GOOD_FLAG, SHARED_RAIL_POWER_GOOD_FLAG,
    FIRST_B_SWITCH_POWER_GOOD_FLAG, THIRD_A_REGULATOR_POWER_GOOD_FLAG,
    COMPANION_POWER_GOOD_FLAGS} | {mb_r, ma_r});
  // Shadow masks; a write lands at the end of its data phase, as in the slave
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mb_r <= MASK_B_RESET;
      ma_r <= MASK_A_RESET;
      wb_r <= 1'b0;
      wa_r <= 1'b0;
    end else begin
      wb_r <= wr_go && HADDR == 8'h00;
      wa_r <= wr_go && HADDR == 8'h04;
      if (wb_r) mb_r <= HWDATA[7:0];
      if (wa_r) ma_r <= HWDATA[7:0];
    end
  end
  ready_always_a: assert property (HREADYOUT) else $error("bus stalled");
  resp_okay_a: assert property (!HRESP) else $error("error response seen");
  rdata_idle_a: assert property (!$past(rd_go) |-> HRDATA == 32'h0) else $error("stray rdata");
  unmapped_zero_a: assert property (rd_go && HADDR > 8'h08 |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (rd_go && HADDR == 8'h00 |=> HRDATA[31:8] == 24'h0)
    else $error("mask upper bits set");
  good_high_a: assert property (good [*4] |-> SECOND_STATUS_OUTPUT_PIN)
    else $error("pin low with all unmasked sources good");
  good_low_a: assert property (!good [*4] |-> !SECOND_STATUS_OUTPUT_PIN)
    else $error("pin high with an unmasked source bad");
  reset_pin_a: assert property (disable iff (1'b0) SRST && $past(SRST) |->
    !SECOND_STATUS_OUTPUT_PIN && HREADYOUT) else $error("pin or ready wrong in reset");
  cover property (good [*4]);
  cover property (!good [*4]);
  cover property (rd_go && HADDR == 8'h08);
endmodule
bind pgtm_top pgtm_monitor #(.MASK_B_RESET(MASK_B_RESET), .MASK_A_RESET(MASK_A_RESET)) mon (
  .CLK, .SRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADYOUT, .HRDATA, .HRESP,
  .FIFTH_CONTROL_INPUT, .FOURTH_CONTROL_INPUT, .SECOND_CONTROL_INPUT, .FIRST_CONTROL_INPUT,
  .TERMINATION_POWER_GOOD_FLAG, .SHARED_RAIL_POWER_GOOD_FLAG, .FIRST_B_SWITCH_POWER_GOOD_FLAG,
  .THIRD_A_REGULATOR_POWER_GOOD_FLAG, .COMPANION_POWER_GOOD_FLAGS, .SECOND_STATUS_OUTPUT_PIN);
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the second status output mask block.
// Assumes the checker binds itself; the slave's hreadyout is fed back as hready.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] mb, src, ma, comp;
    logic       pin;
  } pgtm_row_s;
  // Mask B, sources, mask A, companion flags, expected pin
  // The last five rows show that bits 5 to 1 keep their source in the tree when clear
  pgtm_row_s rows [19] = '{
    '{8'h00, 8'hFF, 8'h00, 8'hFF, 1'b1}, '{8'h80, 8'h7F, 8'h00, 8'hFF, 1'b1},
    '{8'h00, 8'h7F, 8'h00, 8'hFF, 1'b0}, '{8'h40, 8'hBF, 8'h00, 8'hFF, 1'b1},
    '{8'h20, 8'hDF, 8'h00, 8'hFF, 1'b1}, '{8'h10, 8'hEF, 8'h00, 8'hFF, 1'b1},
    '{8'h08, 8'hF7, 8'h00, 8'hFF, 1'b1}, '{8'h04, 8'hFB, 8'h00, 8'hFF, 1'b1},
    '{8'h02, 8'hFD, 8'h00, 8'hFF, 1'b1}, '{8'h01, 8'hFE, 8'h00, 8'hFF, 1'b1},
    '{8'hFE, 8'hFE, 8'h00, 8'hFF, 1'b0}, '{8'hBF, 8'hBF, 8'hFF, 8'h00, 1'b0},
    '{8'hFF, 8'h00, 8'h7F, 8'h80, 1'b1}, '{8'hFF, 8'h00, 8'h00, 8'hFE, 1'b0},
    '{8'h00, 8'hDF, 8'h00, 8'hFF, 1'b0}, '{8'h00, 8'hEF, 8'h00, 8'hFF, 1'b0},
    '{8'h00, 8'hF7, 8'h00, 8'hFF, 1'b0}, '{8'h00, 8'hFB, 8'h00, 8'hFF, 1'b0},
    '{8'h00, 8'hFD, 8'h00, 8'hFF, 1'b0}};
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  hsize = pgtm_pkg::PGTM_HSIZE_WORD;
  logic [7:0]  src = 8'hFF;
  logic [7:0]  comp = 8'hFF;
  logic        hreadyout, hresp, pin;
  logic [31:0] hrdata, rd;
  int          fails = 0;
  int          checks = 0;
  always #5 clk = ~clk;
  pgtm_top uut (.CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
    .FIFTH_CONTROL_INPUT(src[7]), .FOURTH_CONTROL_INPUT(src[6]), .SECOND_CONTROL_INPUT(src[5]),
    .FIRST_CONTROL_INPUT(src[4]), .TERMINATION_POWER_GOOD_FLAG(src[3]),
    .SHARED_RAIL_POWER_GOOD_FLAG(src[2]), .FIRST_B_SWITCH_POWER_GOOD_FLAG(src[1]),
    .THIRD_A_REGULATOR_POWER_GOOD_FLAG(src[0]), .COMPANION_POWER_GOOD_FLAGS(comp),
    .SECOND_STATUS_OUTPUT_PIN(pin));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Looks just before each edge, so the edge's own updates never race the sample
  task automatic phase();
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 16) begin
        fails++;
        end_sim();
      end
      @(negedge clk);
    end
    rd = hrdata;
    @(posedge clk);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= pgtm_pkg::PGTM_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    phase();
    hsel <= 1'b0;
    htrans <= pgtm_pkg::PGTM_HTRANS_IDLE;
    hwdata <= d;
    phase();
  endtask
  // Three edges carry a change to the pin; one spare covers the mask landing
  task automatic pin_chk(input logic e);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("pin", e, pin);
    @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    ahb(1'b0, pgtm_pkg::PGTM_OFS_MASK_B, 32'h0);
    chk("mask b reset", {24'h0, pgtm_pkg::PGTM_RST_MASK_B}, rd);
    ahb(1'b1, 8'h0C, 32'hFF);
    ahb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, pgtm_pkg::PGTM_OFS_STATUS, 32'h0);
    $display("reset and map test done");
    foreach (rows[i]) begin
      src <= rows[i].src;
      comp <= rows[i].comp;
      ahb(1'b1, pgtm_pkg::PGTM_OFS_MASK_B, {24'hFFFFFF, rows[i].mb});
      ahb(1'b1, pgtm_pkg::PGTM_OFS_MASK_A, {24'h0, rows[i].ma});
      pin_chk(rows[i].pin);
      ahb(1'b0, pgtm_pkg::PGTM_OFS_STATUS, 32'h0);
      chk("status", {15'h0, rows[i].pin, rows[i].comp, rows[i].src}, rd);
      ahb(1'b0, pgtm_pkg::PGTM_OFS_MASK_B, 32'h0);
      chk("mask b", {24'h0, rows[i].mb}, rd);
      $display("row %0d test done", i);
    end
    // Raise the pin and move mask A off its reset value, so the reset has work to undo
    src <= 8'h00;
    comp <= 8'hFE;
    ahb(1'b1, pgtm_pkg::PGTM_OFS_MASK_B, 32'h0000_00FF);
    ahb(1'b1, pgtm_pkg::PGTM_OFS_MASK_A, 32'h0000_007F);
    pin_chk(1'b1);
    // Second reset in mid-run: pin drops and the masks return to their reset values
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk("pin in reset", 1'b0, pin);
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    ahb(1'b0, pgtm_pkg::PGTM_OFS_MASK_B, 32'h0);
    chk("mask b reset", {24'h0, pgtm_pkg::PGTM_RST_MASK_B}, rd);
    ahb(1'b0, pgtm_pkg::PGTM_OFS_MASK_A, 32'h0);
    chk("mask a reset", {24'h0, pgtm_pkg::PGTM_RST_MASK_A}, rd);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
